// ### core/liu_rx_pkg.sv
// constants, types and register map of the receive digital path
// Function
// - per-channel T1/J1 or E1 line standard
// - differential or single ended line reception
// - four receive output formats by field
// - single rail: decoded data, recovered clock
// - dual rail NRZ: undecoded rails, clock
// - dual rail RZ: undecoded return-to-zero rails
// - sliced: raw slicer rails, indicator on clock pin
// - three system pins mapped per format
// - indicator source selectable, clock-edge updated except clock and XOR sources
// - data pin polarity by select bit
// - indicator always active high
// - clock edge select for output updates
// - decoder only in single rail format
// - AMI/B8ZS in T1, AMI/HDB3 in E1
// - DPLL recovers clock, holds phase without pulses
// - slicer threshold at half peak amplitude
// - power off: receiver off, line inputs high-Z
// - power off: outputs high-Z or low
// - 1 ms settling after power-on
// - monitor gain 0, 20, 26, 32 dB
// - monitor gain only in differential mode
// - impedance pin low forces external matching
// - single ended forces external matching
`default_nettype none

package liu_rx_pkg;

    // ==========================================================
    // register map (byte offsets)
    localparam logic [4:0] CHAN_CFG_OFS = 5'h00;
    localparam logic [4:0] RCFG0_OFS    = 5'h04;
    localparam logic [4:0] RCFG1_OFS    = 5'h08;
    localparam logic [4:0] RCFG2_OFS    = 5'h0c;
    localparam logic [4:0] STATUS_OFS   = 5'h10;

    localparam logic [7:0] CHAN_CFG_RST = 8'h00;
    localparam logic [7:0] RCFG0_RST    = 8'h00;
    localparam logic [7:0] RCFG1_RST    = 8'h00;
    localparam logic [7:0] RCFG2_RST    = 8'h00;

    // ==========================================================
    // field positions
    localparam int STD_SEL_BIT   = 0;   // channel cfg
    localparam int TERM_LSB      = 0;   // rx cfg 0, two bits resistor value
    localparam int TERM_EXT_BIT  = 2;
    localparam int SING_BIT      = 3;
    localparam int R120_BIT      = 4;
    localparam int OFF_BIT       = 5;
    localparam int TRI_BIT       = 6;
    localparam int FMT_LSB       = 0;   // rx cfg 1
    localparam int CODE_BIT      = 2;
    localparam int INV_BIT       = 3;
    localparam int EDGE_BIT      = 4;
    localparam int IND_LSB       = 5;
    localparam int GAIN_LSB      = 0;   // rx cfg 2

    // ==========================================================
    // timing
    localparam longint CLK_HZ  = 64'd125000000;
    localparam longint T1_HZ   = 64'd1544000;
    localparam longint E1_HZ   = 64'd2048000;
    localparam int     NCO_W   = 24;
    localparam logic [NCO_W-1:0] INC_T1 = NCO_W'((T1_HZ << NCO_W) / CLK_HZ);
    localparam logic [NCO_W-1:0] INC_E1 = NCO_W'((E1_HZ << NCO_W) / CLK_HZ);
    localparam logic [NCO_W-1:0] NUDGE  = 24'h001000;
    localparam int SETTLE_TIME_US = 1000;
    localparam int CLK_MHZ        = 125;
    localparam int SETTLE_CYC     = SETTLE_TIME_US * CLK_MHZ;
    localparam logic [9:0] PEAK_DECAY_CYC = 10'h3ff;
    localparam logic [7:0] PEAK_FLOOR     = 8'h08;

    // line flag limits, in bit periods
    localparam logic [9:0] EXZ_T1_AMI = 10'h00f;
    localparam logic [9:0] EXZ_B8ZS   = 10'h007;
    localparam logic [9:0] EXZ_E1     = 10'h003;
    localparam logic [9:0] LOS_T1     = 10'h0af;
    localparam logic [9:0] LOS_E1     = 10'h020;
    localparam logic [9:0] AIS_RUN    = 10'h200;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        FMT_SINGLE = 2'h0,
        FMT_NRZ    = 2'h1,
        FMT_RZ     = 2'h2,
        FMT_SLICED = 2'h3
    } fmt_t;

    typedef enum logic [2:0] {
        IND_PRBS = 3'h0, IND_AIS = 3'h1, IND_EXZ = 3'h2, IND_BPV = 3'h3,
        IND_EXZ_BPV = 3'h4, IND_LOS = 3'h5, IND_RCLK = 3'h6, IND_XOR = 3'h7
    } ind_t;

    typedef enum logic [1:0] {
        PWR_ON     = 2'h3,
        PWR_OFF    = 2'h0,
        PWR_SETTLE = 2'h1
    } pwr_t;

    typedef struct packed {
        logic p;
        logic n;
    } sym_t;

    typedef struct packed {
        logic ais;
        logic exz;
        logic bpv;
        logic los;
    } line_flags_t;

endpackage

`default_nettype wire

// ### core/liu_receive_digital_path.sv
// receive digital path of one line channel with its register slave
//
// Implementation choices: register access over Avalon-MM and the address map.
`default_nettype none

module liu_receive_digital_path #(
    parameter int SETTLE_CYCLES = liu_rx_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // register bus
    input  wire logic [4:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output var  logic [31:0]       readdata,
    output var  logic              waitrequest,
    // line side: signed amplitude samples on clk, and analog controls
    input  wire logic signed [7:0] line_in_pos,
    input  wire logic signed [7:0] line_in_neg,
    output var  logic              line_in_hiz,
    output var  logic              term_internal_en,
    output var  logic              term_partial_sel,
    output var  logic [1:0]        term_res_sel,
    output var  logic [1:0]        monitor_gain_sel,
    // global pins
    input  wire logic              global_impedance_ctrl_pin,
    input  wire logic              std_per_channel_n,
    input  wire logic              std_pin_t1,
    input  wire logic              prbs_arb_ind,
    // system side pins: data, negative rail or indicator, clock or indicator
    output var  logic              rx_pin_a,
    output var  logic              rx_pin_a_oe_n,
    output var  logic              rx_pin_b,
    output var  logic              rx_pin_b_oe_n,
    output var  logic              rx_pin_c,
    output var  logic              rx_pin_c_oe_n
);

    // ==========================================================
    // registers and pin synchronisers
    logic [7:0] channel_cfg_reg, rx_cfg_reg0, rx_cfg_reg1, rx_cfg_reg2;
    logic       wait_reg;
    logic [31:0] rdata_reg;
    logic [2:0] pin_s1_reg, pin_s2_reg;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end
        else
        begin
            pin_s1_reg <= {global_impedance_ctrl_pin, std_per_channel_n, std_pin_t1};
            pin_s2_reg <= pin_s1_reg;
        end

    wire rim_s       = pin_s2_reg[2];
    wire per_chan_n  = pin_s2_reg[1];
    wire pin_t1      = pin_s2_reg[0];

    wire is_e1       = per_chan_n ? ~pin_t1 : channel_cfg_reg[liu_rx_pkg::STD_SEL_BIT];
    wire single_end  = rx_cfg_reg0[liu_rx_pkg::SING_BIT];
    wire pwr_off     = rx_cfg_reg0[liu_rx_pkg::OFF_BIT];
    wire out_tri     = rx_cfg_reg0[liu_rx_pkg::TRI_BIT];
    liu_rx_pkg::fmt_t fmt;
    liu_rx_pkg::ind_t ind_sel;
    assign fmt       = liu_rx_pkg::fmt_t'(rx_cfg_reg1[liu_rx_pkg::FMT_LSB +: 2]);
    assign ind_sel   = liu_rx_pkg::ind_t'(rx_cfg_reg1[liu_rx_pkg::IND_LSB +: 3]);
    wire use_hdb3    = rx_cfg_reg1[liu_rx_pkg::CODE_BIT];
    wire data_inv    = rx_cfg_reg1[liu_rx_pkg::INV_BIT];
    wire edge_rise   = rx_cfg_reg1[liu_rx_pkg::EDGE_BIT];

    // ==========================================================
    // register bus: every access answers after one wait cycle
    liu_rx_pkg::pwr_t pwr_reg, pwr_next;
    liu_rx_pkg::line_flags_t flags_reg;
    wire req       = read | write;
    wire take      = req & ~wait_reg;
    wire wr_en     = write & take & byteenable[0];
    wire [7:0] status_val = {1'b0, is_e1, term_internal_en, pwr_reg == liu_rx_pkg::PWR_SETTLE,
                             flags_reg.los, flags_reg.bpv, flags_reg.exz, flags_reg.ais};
    wire [7:0] rd_mux =
        (address == liu_rx_pkg::CHAN_CFG_OFS) ? channel_cfg_reg :
        (address == liu_rx_pkg::RCFG0_OFS)    ? rx_cfg_reg0 :
        (address == liu_rx_pkg::RCFG1_OFS)    ? rx_cfg_reg1 :
        (address == liu_rx_pkg::RCFG2_OFS)    ? rx_cfg_reg2 :
        (address == liu_rx_pkg::STATUS_OFS)   ? status_val : 8'h00;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            wait_reg        <= 1'b1;
            rdata_reg       <= 32'h0000_0000;
            channel_cfg_reg <= liu_rx_pkg::CHAN_CFG_RST;
            rx_cfg_reg0     <= liu_rx_pkg::RCFG0_RST;
            rx_cfg_reg1     <= liu_rx_pkg::RCFG1_RST;
            rx_cfg_reg2     <= liu_rx_pkg::RCFG2_RST;
        end
        else
        begin
            wait_reg  <= wait_reg ? ~req : 1'b1;
            rdata_reg <= {24'h00_0000, rd_mux};
            if (wr_en && address == liu_rx_pkg::CHAN_CFG_OFS)
                channel_cfg_reg <= writedata[7:0];
            if (wr_en && address == liu_rx_pkg::RCFG0_OFS)
                rx_cfg_reg0 <= writedata[7:0];
            if (wr_en && address == liu_rx_pkg::RCFG1_OFS)
                rx_cfg_reg1 <= writedata[7:0];
            if (wr_en && address == liu_rx_pkg::RCFG2_OFS)
                rx_cfg_reg2 <= writedata[7:0];
        end

    assign waitrequest = wait_reg;
    assign readdata    = rdata_reg;

    // ==========================================================
    // power state: off, settling, on
    logic [16:0] settle_cnt_reg;
    always_comb
    begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            liu_rx_pkg::PWR_ON:     if (pwr_off) pwr_next = liu_rx_pkg::PWR_OFF;
            liu_rx_pkg::PWR_OFF:    if (!pwr_off) pwr_next = liu_rx_pkg::PWR_SETTLE;
            liu_rx_pkg::PWR_SETTLE:
                if (pwr_off)
                    pwr_next = liu_rx_pkg::PWR_OFF;
                else if (settle_cnt_reg == 17'(SETTLE_CYCLES - 1))
                    pwr_next = liu_rx_pkg::PWR_ON;
            default:                pwr_next = liu_rx_pkg::PWR_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            pwr_reg        <= liu_rx_pkg::PWR_ON;
            settle_cnt_reg <= 17'h0_0000;
        end
        else
        begin
            pwr_reg        <= pwr_next;
            settle_cnt_reg <= (pwr_reg == liu_rx_pkg::PWR_SETTLE) ? settle_cnt_reg + 17'h1 : 17'h0;
        end

    // ==========================================================
    // analog controls
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            line_in_hiz      <= 1'b0;
            term_internal_en <= 1'b0;
            term_partial_sel <= 1'b0;
            term_res_sel     <= 2'h0;
            monitor_gain_sel <= 2'h0;
        end
        else
        begin
            line_in_hiz      <= pwr_off;
            term_internal_en <= rim_s & ~single_end & ~pwr_off
                                & ~rx_cfg_reg0[liu_rx_pkg::TERM_EXT_BIT];
            term_partial_sel <= ~rx_cfg_reg0[liu_rx_pkg::R120_BIT];
            term_res_sel     <= rx_cfg_reg0[liu_rx_pkg::TERM_LSB +: 2];
            monitor_gain_sel <= single_end ? 2'h0 : rx_cfg_reg2[liu_rx_pkg::GAIN_LSB +: 2];
        end

    // ==========================================================
    // slicer: threshold tracks half of a slowly decaying peak
    wire signed [8:0] diff9  = {line_in_pos[7], line_in_pos} - {line_in_neg[7], line_in_neg};
    // single ended uses the positive input only
    wire signed [8:0] level  = single_end ? {line_in_pos[7], line_in_pos} : (diff9 >>> 1);
    wire        [8:0] mag9   = level[8] ? 9'(-level) : 9'(level);
    wire        [7:0] mag    = mag9[7:0];
    logic [7:0] peak_reg;
    logic [9:0] decay_cnt_reg;
    liu_rx_pkg::sym_t slice_reg, seen_reg, bit_reg;
    logic slice_any_d_reg;
    wire  [7:0] thr = peak_reg >> 1;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            peak_reg      <= liu_rx_pkg::PEAK_FLOOR;
            decay_cnt_reg <= 10'h000;
            slice_reg     <= '0;
        end
        else if (pwr_off)
        begin
            peak_reg  <= liu_rx_pkg::PEAK_FLOOR;
            slice_reg <= '0;
        end
        else
        begin
            decay_cnt_reg <= decay_cnt_reg + 10'h1;
            if (mag > peak_reg)
                peak_reg <= mag;
            else if (decay_cnt_reg == liu_rx_pkg::PEAK_DECAY_CYC && peak_reg > liu_rx_pkg::PEAK_FLOOR)
                peak_reg <= peak_reg - 8'h1;
            slice_reg.p <= ~level[8] & (mag > thr);
            slice_reg.n <=  level[8] & (mag > thr);
        end

    // ==========================================================
    // DPLL: NCO whose phase is nudged toward each mark's leading edge;
    // with no marks it free-runs, so clock and data phase are kept
    logic [liu_rx_pkg::NCO_W-1:0] phase_reg;
    logic msb_d_reg;
    wire  slice_any  = slice_reg.p | slice_reg.n;
    wire  mark_start = slice_any & ~slice_any_d_reg;
    wire  [liu_rx_pkg::NCO_W-1:0] inc = is_e1 ? liu_rx_pkg::INC_E1 : liu_rx_pkg::INC_T1;
    wire  [liu_rx_pkg::NCO_W-1:0] adj =
        !mark_start ? '0 :
        phase_reg[liu_rx_pkg::NCO_W-1] ? liu_rx_pkg::NUDGE : liu_rx_pkg::NCO_W'(-liu_rx_pkg::NUDGE);
    wire  [liu_rx_pkg::NCO_W:0] psum = {1'b0, phase_reg} + {1'b0, inc};
    wire  bit_wrap   = psum[liu_rx_pkg::NCO_W];
    wire  rclk_int   = ~phase_reg[liu_rx_pkg::NCO_W-1];
    wire  rclk_fall  = phase_reg[liu_rx_pkg::NCO_W-1] & ~msb_d_reg;
    wire  upd        = edge_rise ? bit_wrap : rclk_fall;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            phase_reg       <= '0;
            msb_d_reg       <= 1'b0;
            slice_any_d_reg <= 1'b0;
            seen_reg        <= '0;
            bit_reg         <= '0;
        end
        else
        begin
            phase_reg       <= pwr_off ? '0 : psum[liu_rx_pkg::NCO_W-1:0] + adj;
            msb_d_reg       <= phase_reg[liu_rx_pkg::NCO_W-1];
            slice_any_d_reg <= slice_any;
            seen_reg        <= bit_wrap ? slice_reg : (seen_reg | slice_reg);
            if (bit_wrap)
                bit_reg <= seen_reg;
        end

    // ==========================================================
    // decoder: eight symbol window, index 7 is the oldest
    logic [7:0] raw_p_reg, raw_n_reg, kill_reg;
    logic       last_pol_reg, dec_reg;
    logic [9:0] zero_run_reg, one_run_reg;
    wire  [7:0] sp = {raw_p_reg[6:0], bit_reg.p};
    wire  [7:0] sn = {raw_n_reg[6:0], bit_reg.n};
    wire  [7:0] m  = sp | sn;
    wire  out_mark = raw_p_reg[7] | raw_n_reg[7];
    wire  lp       = out_mark ? raw_p_reg[7] : last_pol_reg;
    wire  b8zs_hit = ~is_e1 & ~use_hdb3 & ~m[7] & ~m[6] & ~m[5] & ~m[2]
                     & m[4] & m[3] & m[1] & m[0]
                     & (sp[4] == lp) & (sp[3] != lp) & (sp[1] != lp) & (sp[0] == lp);
    wire  hdb3_hit = is_e1 & use_hdb3 & ~m[6] & ~m[5] & m[4]
                     & (m[7] ? (sp[7] == sp[4]) : (sp[4] == lp));
    wire  [7:0] kill_new = {kill_reg[6:0], 1'b0}
                           | (b8zs_hit ? 8'h1b : 8'h00) | (hdb3_hit ? 8'h90 : 8'h00);
    wire  dec_bit  = out_mark & ~kill_reg[7];
    // code bit set in T1 selects the B8ZS zero-run limit, shorter than AMI's; the decoder strips B8ZS only with the bit clear
    wire  [9:0] exz_lim = is_e1 ? liu_rx_pkg::EXZ_E1 :
                          use_hdb3 ? liu_rx_pkg::EXZ_B8ZS : liu_rx_pkg::EXZ_T1_AMI;
    wire  [9:0] exz_sel = exz_lim;
    wire  [9:0] los_lim = is_e1 ? liu_rx_pkg::LOS_E1 : liu_rx_pkg::LOS_T1;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            raw_p_reg    <= 8'h00;
            raw_n_reg    <= 8'h00;
            kill_reg     <= 8'h00;
            last_pol_reg <= 1'b0;
            dec_reg      <= 1'b0;
            zero_run_reg <= 10'h000;
            one_run_reg  <= 10'h000;
            flags_reg    <= '0;
        end
        else if (bit_wrap)
        begin
            raw_p_reg    <= sp;
            raw_n_reg    <= sn;
            kill_reg     <= kill_new;
            last_pol_reg <= lp;
            dec_reg      <= dec_bit;
            zero_run_reg <= out_mark ? 10'h000 : zero_run_reg + {9'h000, ~&zero_run_reg};
            one_run_reg  <= dec_bit ? one_run_reg + {9'h000, ~&one_run_reg} : 10'h000;
            flags_reg.exz <= ~out_mark & (zero_run_reg == exz_sel);
            flags_reg.bpv <= out_mark & ~kill_reg[7] & (raw_p_reg[7] == last_pol_reg);
            flags_reg.los <= ~out_mark & (zero_run_reg >= los_lim);
            flags_reg.ais <= one_run_reg >= liu_rx_pkg::AIS_RUN;
        end

    // ==========================================================
    // system side pin mapping
    logic hold_a_reg, hold_b_reg, ind_hold_reg;
    wire  ind_flag =
        (ind_sel == liu_rx_pkg::IND_PRBS)    ? prbs_arb_ind :
        (ind_sel == liu_rx_pkg::IND_AIS)     ? flags_reg.ais :
        (ind_sel == liu_rx_pkg::IND_EXZ)     ? flags_reg.exz :
        (ind_sel == liu_rx_pkg::IND_BPV)     ? flags_reg.bpv :
        (ind_sel == liu_rx_pkg::IND_EXZ_BPV) ? (flags_reg.exz | flags_reg.bpv) :
        flags_reg.los;
    wire  ind_val =
        (ind_sel == liu_rx_pkg::IND_RCLK) ? rclk_int :
        (ind_sel == liu_rx_pkg::IND_XOR)  ? (slice_reg.p ^ slice_reg.n) : ind_hold_reg;
    // decoded data only in single rail
    wire  next_a = (fmt == liu_rx_pkg::FMT_SINGLE) ? dec_reg : bit_reg.p;
    wire  pin_a_val =
        (fmt == liu_rx_pkg::FMT_SLICED) ? slice_reg.p :
        (fmt == liu_rx_pkg::FMT_RZ)     ? (hold_a_reg & rclk_int) : hold_a_reg;
    wire  pin_b_val =
        (fmt == liu_rx_pkg::FMT_SLICED) ? slice_reg.n :
        (fmt == liu_rx_pkg::FMT_RZ)     ? (hold_b_reg & rclk_int) : hold_b_reg;
    wire  a_drv = pin_a_val ^ data_inv;
    wire  b_drv = (fmt == liu_rx_pkg::FMT_SINGLE) ? ind_val : (pin_b_val ^ data_inv);
    wire  c_drv = (fmt == liu_rx_pkg::FMT_SLICED) ? ind_val : rclk_int;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            hold_a_reg    <= 1'b0;
            hold_b_reg    <= 1'b0;
            ind_hold_reg  <= 1'b0;
            rx_pin_a      <= 1'b0;
            rx_pin_b      <= 1'b0;
            rx_pin_c      <= 1'b0;
            rx_pin_a_oe_n <= 1'b0;
            rx_pin_b_oe_n <= 1'b0;
            rx_pin_c_oe_n <= 1'b0;
        end
        else
        begin
            if (upd)
            begin
                hold_a_reg   <= next_a;
                hold_b_reg   <= bit_reg.n;
                ind_hold_reg <= ind_flag;
            end
            rx_pin_a      <= ~pwr_off & a_drv;
            rx_pin_b      <= ~pwr_off & b_drv;
            rx_pin_c      <= ~pwr_off & c_drv;
            rx_pin_a_oe_n <= pwr_off & out_tri;
            rx_pin_b_oe_n <= pwr_off & out_tri;
            rx_pin_c_oe_n <= pwr_off & out_tri;
        end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    bus_answer_a: assert property (req && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("bus access not answered after one wait cycle");
    pwr_hiz_a: assert property (pwr_off && out_tri |=> rx_pin_a_oe_n && rx_pin_c_oe_n)
        else $error("pins not released in power down");
    pwr_low_a: assert property (pwr_off && !out_tri
                                |=> !rx_pin_b_oe_n && !rx_pin_a && !rx_pin_b)
        else $error("pins not driven low in power down");
    line_hiz_a: assert property (pwr_off |=> line_in_hiz)
        else $error("line inputs not released in power down");
    gain_single_a: assert property (single_end |=> monitor_gain_sel == 2'h0)
        else $error("monitor gain active in single ended mode");
    term_ext_a: assert property (!rim_s || single_end |=> !term_internal_en)
        else $error("internal termination despite external-only condition");
    settle_start_a: assert property ($fell(pwr_off) |=> pwr_reg == liu_rx_pkg::PWR_SETTLE)
        else $error("no settling after power on");
    sliced_ind_a: assert property (fmt == liu_rx_pkg::FMT_SLICED && !pwr_off && $stable(fmt)
                                   |=> rx_pin_c == $past(ind_val))
        else $error("indicator missing on clock pin in sliced mode");

endmodule // liu_receive_digital_path

`default_nettype wire

// ### verification/rx_framer_model.sv
// framer-side model that counts recovered clock edges
`default_nettype none

module rx_framer_model (
    // clock and control
    input  wire logic        clk,
    input  wire logic        clr,
    // resolved clock pin
    input  wire logic        pin_c,
    output var  logic [15:0] edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg;
    always_ff @(posedge clk)
    begin
        last_reg <= pin_c;
        edges    <= clr ? 16'h0 : edges + 16'(pin_c & ~last_reg);
    end
endmodule // rx_framer_model

`default_nettype wire

// ### verification/liu_receive_digital_path_test.sv
// self-checking bench of the receive digital path
`default_nettype none

module liu_receive_digital_path_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and wiring
    logic clk = 0, rstn = 0, rd = 0, wr = 0, gpin = 1, prbs = 0, clr = 1;
    logic line_on = 1, pol = 0, wreq, a, ao, b, bo, c, co, hiz, tint, tp;
    logic [4:0]  address = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [1:0]  gain, tr;
    logic [6:0]  ph = 7'h0, per = 7'h50;
    logic [15:0] edges;
    logic signed [7:0] lp = 8'sh0, ln = 8'sh0;
    int fails = 0, n_tests = 0;
    wire logic signed [7:0] amp = (line_on && ph < per / 2) ? (pol ? 8'sd60 : -8'sd60) : 8'sd0;
    // released pin reads as pulled low
    wire logic c_wire = co ? 1'b0 : c;
    always #4 clk = ~clk;
    // alternate-mark line pulses, one per bit period
    always @(posedge clk)
    begin
        ph <= (ph >= per) ? 7'h0 : ph + 7'h1;
        pol <= (ph >= per) ? ~pol : pol;
        lp <= amp;
        ln <= -amp;
    end
    liu_receive_digital_path #(.SETTLE_CYCLES(20)) liu_receive_digital_path_inst (
        .clk(clk), .rstn(rstn), .address(address), .read(rd), .write(wr),
        .writedata(wdata), .byteenable(4'hf), .readdata(rdata), .waitrequest(wreq),
        .line_in_pos(lp), .line_in_neg(ln), .line_in_hiz(hiz), .term_internal_en(tint),
        .term_partial_sel(tp), .term_res_sel(tr), .monitor_gain_sel(gain),
        .global_impedance_ctrl_pin(gpin), .std_per_channel_n(1'b0), .std_pin_t1(1'b1),
        .prbs_arb_ind(prbs), .rx_pin_a(a), .rx_pin_a_oe_n(ao), .rx_pin_b(b),
        .rx_pin_b_oe_n(bo), .rx_pin_c(c), .rx_pin_c_oe_n(co));
    rx_framer_model rx_framer_model_inst (.clk(clk), .clr(clr), .pin_c(c_wire), .edges(edges));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic wnr, input logic [4:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= ad;
        rd <= !wnr;
        wr <= wnr;
        wdata <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        // one wait cycle: the answer is seen at the second edge after the request rises
        chk(n, 32'h2);
    endtask
    task automatic rate(input logic [15:0] lo, input logic [15:0] hi);
        w(400);
        clr <= 1'b1;
        w(1);
        clr <= 1'b0;
        w(10000);
        chk(32'(edges >= lo && edges <= hi), 32'h1);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        for (int i = 0; i < 5; i++)
        begin
            bus(0, 5'(i * 4) + (i == 4 ? 5'h4 : 5'h0), 8'h0);
            chk(q, 0);
        end
        bus(1, 5'h14, 8'h77);
        bus(0, 5'h14, 8'h0);
        chk(q, 0);
        bus(1, 5'h08, 8'h5a);
        bus(0, 5'h08, 8'h0);
        chk(q, 32'h5a);
        bus(1, 5'h08, 8'h00);
    endtask
    task automatic t_std();
        rate(16'd111, 16'd136);
        per <= 7'h3c;
        bus(1, 5'h00, 8'h01);
        bus(0, 5'h10, 8'h0);
        chk(q[6], 1);
        rate(16'd148, 16'd180);
        bus(1, 5'h08, 8'h01);
        rate(16'd148, 16'd180);
    endtask
    task automatic t_sliced();
        prbs <= 1'b1;
        bus(1, 5'h08, 8'h0b);
        w(200);
        chk(c, 1);
        prbs <= 1'b0;
        w(200);
        chk(c, 0);
        bus(1, 5'h08, 8'hc3);
        rate(16'd148, 16'd180);
    endtask
    task automatic t_pol();
        line_on <= 1'b0;
        bus(1, 5'h08, 8'h01);
        w(500);
        chk({a, b}, 2'b00);
        bus(1, 5'h08, 8'h09);
        w(500);
        chk({a, b}, 2'b11);
        line_on <= 1'b1;
        bus(1, 5'h08, 8'h00);
        // a mark in every bit period decodes to all ones under AMI
        w(2000);
        chk(a, 1);
        bus(1, 5'h08, 8'h08);
        w(200);
        chk(a, 0);
        bus(1, 5'h08, 8'h00);
    endtask
    task automatic t_power();
        bus(1, 5'h04, 8'h60);
        w(3);
        chk({ao, bo, co, hiz}, 4'hf);
        bus(1, 5'h04, 8'h20);
        w(3);
        chk({ao, bo, co, a, b, c}, 6'h0);
        bus(1, 5'h04, 8'h00);
        bus(0, 5'h10, 8'h0);
        chk({q[4], hiz}, 2'b10);
        w(40);
        bus(0, 5'h10, 8'h0);
        chk(q[4], 0);
    endtask
    task automatic t_term();
        bus(1, 5'h0c, 8'h03);
        w(5);
        chk({tint, gain}, 3'b111);
        gpin <= 1'b0;
        w(5);
        chk(tint, 0);
        gpin <= 1'b1;
        bus(1, 5'h04, 8'h08);
        w(5);
        chk({tint, gain}, 3'b000);
        bus(1, 5'h04, 8'h00);
    endtask
    initial
    begin
        w(10);
        rstn <= 1'b1;
        t_regs();
        t_std();
        t_sliced();
        t_pol();
        t_power();
        t_term();
        tally_and_finish();
    end
    initial
    begin
        // the scenarios need about 45,000 cycles; give up at 75,000
        #600_000;
        fails++;
        tally_and_finish();
    end
endmodule // liu_receive_digital_path_test

`default_nettype wire
